// [verilog/ces_regs.svh]
`ifndef CES_REGS_SVH
`define CES_REGS_SVH

// retry limit setting: default and top of range
`define CES_RETRY_DEFAULT   16'h0001
`define CES_RETRY_MAX       16'h000A
// shared "function off" code for retry limit and silence timeout
`define CES_DISABLE_CODE    16'h270F
// silence timeout setting in tenths of a second
`define CES_TIMEOUT_DEFAULT 16'h0000
`define CES_TIMEOUT_MAX     16'h270E
// fault stop mode setting
`define CES_STOP_DEFAULT    2'h0
`define CES_STOP_DECEL      2'h1
`define CES_STOP_RESTART    2'h2
// output terminal function codes for the minor alarm
`define CES_LF_POS_CODE     16'h0062
`define CES_LF_NEG_CODE     16'h00C6
// consecutive error counter saturation
`define CES_ERR_SAT         4'hF
// silence timer base: 0.1 s at a 5 ns clock
`define CES_TICK_NS         32'h05F5_E100
`define CES_CLK_NS          32'h0000_0005
`define CES_TICK_CYCLES     (`CES_TICK_NS / `CES_CLK_NS)

`endif

// [verilog/ces_pkg.sv]
package ces_pkg;

  // which setting a write targets
  typedef enum logic [1:0] {
    CES_SEL_RETRY,
    CES_SEL_TIMEOUT,
    CES_SEL_STOP,
    CES_SEL_NONE
  } ces_sel_e;

  // supervisor state
  typedef enum logic [2:0] {
    CES_ST_RUN,
    CES_ST_COAST,
    CES_ST_DECEL,
    CES_ST_TRIPPED,
    CES_ST_HOLD
  } ces_state_e;

  // live copy of the three supervisor settings
  typedef struct packed {
    logic [15:0] retry_limit;
    logic [15:0] timeout;
    logic [1:0]  stop_mode;
  } ces_cfg_s;

  // motor-side commands toward the ramp generator
  typedef struct packed {
    logic coast;
    logic decel;
    logic restart;
  } ces_motor_s;

endpackage

// [verilog/ces_term_map.sv]
`timescale 1ns/1ps
`include "ces_regs.svh"

module ces_term_map #(
  parameter int N_TERM = 3
) (
  // clock and reset
  input  wire logic                   i_mclk,
  input  wire logic                   i_rst,
  // alarm level and terminal assignments
  input  wire logic                   i_minor,
  input  wire logic [N_TERM-1:0][15:0] i_func,
  // terminal levels
  output logic      [N_TERM-1:0]      o_term
);

  initial begin
    if (N_TERM < 1) begin
      $error("ces_term_map: N_TERM must be at least 1");
    end
  end

  // one output flop per terminal; unassigned terminals stay low
  for (genvar t = 0; t < N_TERM; t++) begin : g_term
    always_ff @(posedge i_mclk) begin
      if (i_rst) begin
        o_term[t] <= 1'b0;
      end else if (i_func[t] == `CES_LF_POS_CODE) begin
        o_term[t] <= i_minor;
      end else if (i_func[t] == `CES_LF_NEG_CODE) begin
        o_term[t] <= ~i_minor;
      end else begin
        o_term[t] <= 1'b0;
      end
    end
  end

endmodule

// [verilog/ces_supervisor.sv]
// Behaviour
// - after any link setting change, refuse link traffic until reset.
// - retry limit holds 0 to 10, defaults to 1 after reset.
// - consecutive receive errors above limit trip the link fault, stop per mode.
// - retry limit 9999 never trips; each receive error raises minor alarm.
// - minor alarm reaches a terminal only with code 98 or 198.
// - timeout 0 keeps link usable; trips at once in link command mode.
// - timeout 0.1 to 999.8 s trips once silence outlasts the interval.
// - stop mode 1 decelerates, then shows fault and fault output; stays stopped.
// - settings writable only when read select is 0 or option attached.
// - timeout 9999 disables silence checking entirely.
// - any received frame clears the silence timer, any station number.
// - stop mode 2 restarts automatically with prior commands once fault clears.
// - stop modes 0 and 3 coast, show fault and output, stay stopped.
`timescale 1ns/1ps
`include "ces_regs.svh"

module ces_supervisor #(
  parameter int N_TERM      = 3,
  parameter int TICK_CYCLES = `CES_TICK_CYCLES
) (
  // clock and reset
  input  wire logic                    i_mclk,
  input  wire logic                    i_rst,
  // link events from the frame parser
  input  wire logic                    i_frame_ok,
  input  wire logic                    i_frame_err,
  input  wire logic                    i_cfg_changed,
  input  wire logic                    i_link_cmd_mode,
  // setting writes
  input  wire logic                    i_set_wr,
  input  wire ces_pkg::ces_sel_e       i_set_sel,
  input  wire logic [15:0]             i_set_data,
  input  wire logic [15:0]             i_user_group_read_select,
  input  wire logic                    i_comm_opt_attached,
  input  wire logic [N_TERM-1:0][15:0] i_output_terminal_function,
  // ramp generator status
  input  wire logic                    i_motor_stopped,
  // status and control outputs
  output logic                         o_link_enable,
  output logic                         o_set_ack,
  output logic                         o_set_nak,
  output ces_pkg::ces_motor_s          o_motor,
  output logic                         o_comm_fault_trip,
  output logic                         o_fault_out,
  output logic                         o_minor_fault_alarm,
  output logic [3:0]                   o_err_count,
  output logic [N_TERM-1:0]            o_term
);

  initial begin
    if (TICK_CYCLES < 1) begin
      $error("ces_supervisor: TICK_CYCLES must be at least 1");
    end
  end

  ces_pkg::ces_cfg_s   cfg_reg;
  ces_pkg::ces_cfg_s   pend_reg = '{`CES_RETRY_DEFAULT, `CES_TIMEOUT_DEFAULT, `CES_STOP_DEFAULT};
  ces_pkg::ces_state_e state_reg;
  ces_pkg::ces_state_e state_next;
  logic                refuse_reg;
  logic [3:0]          err_cnt_reg;
  logic                minor_reg;
  logic                armed_reg;
  logic [31:0]         tick_reg;
  logic [15:0]         tenths_reg;
  logic                rx_ok;
  logic                rx_err;
  logic                rx_any;
  logic                wr_allowed;
  logic                wr_in_range;
  logic                retry_trip;
  logic                zero_trip;
  logic                silence_trip;
  logic                trip_evt;
  logic                mode2_clear;
  logic [4:0]          err_plus;

  // frames are ignored while the link is refused
  // gate link traffic
  assign rx_ok  = i_frame_ok & ~refuse_reg;
  assign rx_err = i_frame_err & ~refuse_reg;
  assign rx_any = rx_ok | rx_err;

  // write permission and range check
  // write permission
  assign wr_allowed = (i_user_group_read_select == 16'h0000) | i_comm_opt_attached;
  always_comb begin
    case (i_set_sel)
      ces_pkg::CES_SEL_RETRY:   wr_in_range = (i_set_data <= `CES_RETRY_MAX) |
                                              (i_set_data == `CES_DISABLE_CODE);
      ces_pkg::CES_SEL_TIMEOUT: wr_in_range = (i_set_data <= `CES_DISABLE_CODE);
      ces_pkg::CES_SEL_STOP:    wr_in_range = (i_set_data <= 16'h0003);
      default:                  wr_in_range = 1'b0;
    endcase
  end

  // pending copy survives reset and only goes live when reset is applied
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      cfg_reg <= pend_reg;
    end
    if (i_set_wr && wr_allowed && wr_in_range) begin
      case (i_set_sel)
        ces_pkg::CES_SEL_RETRY:   pend_reg.retry_limit <= i_set_data;
        ces_pkg::CES_SEL_TIMEOUT: pend_reg.timeout     <= i_set_data;
        ces_pkg::CES_SEL_STOP:    pend_reg.stop_mode   <= i_set_data[1:0];
        default:                  pend_reg.stop_mode   <= pend_reg.stop_mode;
      endcase
    end
  end

  // write answers, one cycle after the request
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_set_ack <= 1'b0;
      o_set_nak <= 1'b0;
    end else begin
      o_set_ack <= i_set_wr & wr_allowed & wr_in_range;
      o_set_nak <= i_set_wr & ~(wr_allowed & wr_in_range);
    end
  end

  // link refusal latch; only a reset releases it
  // refuse after change
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      refuse_reg <= 1'b0;
    end else if (i_cfg_changed || (i_set_wr && wr_allowed && wr_in_range)) begin
      refuse_reg <= 1'b1;
    end
  end

  // consecutive receive error counter, saturating
  assign err_plus = {1'b0, err_cnt_reg} + 5'h01;
  always_ff @(posedge i_mclk) begin
    if (i_rst || mode2_clear) begin
      err_cnt_reg <= 4'h0;
    end else if (rx_err) begin
      if (err_cnt_reg != `CES_ERR_SAT) begin
        err_cnt_reg <= err_plus[3:0];
      end
    end else if (rx_ok) begin
      err_cnt_reg <= 4'h0;
    end
  end

  assign retry_trip = rx_err && (cfg_reg.retry_limit != `CES_DISABLE_CODE) &&
                      ({11'h000, err_plus} > cfg_reg.retry_limit);

  // minor alarm holds until an error-free frame; a new error wins
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      minor_reg <= 1'b0;
    end else if (rx_err && (cfg_reg.retry_limit == `CES_DISABLE_CODE)) begin
      minor_reg <= 1'b1;
    end else if (rx_ok || (cfg_reg.retry_limit != `CES_DISABLE_CODE)) begin
      minor_reg <= 1'b0;
    end
  end

  // silence checking starts at the first frame in link command mode
  always_ff @(posedge i_mclk) begin
    if (i_rst || !i_link_cmd_mode || mode2_clear) begin
      armed_reg <= 1'b0;
    end else if (rx_any) begin
      armed_reg <= 1'b1;
    end
  end

  // silence timer: cycle prescaler and count of elapsed tenths
  always_ff @(posedge i_mclk) begin
    if (i_rst || rx_any || !armed_reg) begin
      tick_reg   <= 32'h0000_0000;
      tenths_reg <= 16'h0000;
    end else if (tick_reg == 32'(TICK_CYCLES - 1)) begin
      tick_reg <= 32'h0000_0000;
      if (tenths_reg != 16'hFFFF) begin
        tenths_reg <= tenths_reg + 16'h0001;
      end
    end else begin
      tick_reg <= tick_reg + 32'h0000_0001;
    end
  end

  assign silence_trip = armed_reg && !rx_any &&
                        (cfg_reg.timeout != 16'h0000) &&
                        (cfg_reg.timeout != `CES_DISABLE_CODE) &&
                        (tenths_reg > cfg_reg.timeout);
  // zero timeout trips in command mode
  assign zero_trip = i_link_cmd_mode && (cfg_reg.timeout == 16'h0000);

  assign trip_evt = retry_trip | silence_trip | zero_trip;

  assign mode2_clear = rx_ok && !zero_trip &&
                       ((state_reg == ces_pkg::CES_ST_DECEL) ||
                        (state_reg == ces_pkg::CES_ST_HOLD)) &&
                       (cfg_reg.stop_mode == `CES_STOP_RESTART);

  // stop policy sequencing
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ces_pkg::CES_ST_RUN: begin
        if (trip_evt) begin
          if (cfg_reg.stop_mode == `CES_STOP_DECEL ||
              cfg_reg.stop_mode == `CES_STOP_RESTART) begin
            state_next = ces_pkg::CES_ST_DECEL;
          end else begin
            state_next = ces_pkg::CES_ST_COAST;
          end
        end
      end
      ces_pkg::CES_ST_COAST: begin
        state_next = ces_pkg::CES_ST_TRIPPED;
      end
      ces_pkg::CES_ST_DECEL: begin
        if (mode2_clear) begin
          state_next = ces_pkg::CES_ST_RUN;
        end else if (i_motor_stopped) begin
          if (cfg_reg.stop_mode == `CES_STOP_RESTART) begin
            state_next = ces_pkg::CES_ST_HOLD;
          end else begin
            state_next = ces_pkg::CES_ST_TRIPPED;
          end
        end
      end
      ces_pkg::CES_ST_HOLD: begin
        if (mode2_clear) begin
          state_next = ces_pkg::CES_ST_RUN;
        end
      end
      ces_pkg::CES_ST_TRIPPED: begin
        state_next = ces_pkg::CES_ST_TRIPPED;
      end
      default: begin
        state_next = ces_pkg::CES_ST_TRIPPED;
      end
    endcase
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      state_reg <= ces_pkg::CES_ST_RUN;
    end else begin
      state_reg <= state_next;
    end
  end

  // registered outputs, one cycle behind the state
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_motor             <= '0;
      o_comm_fault_trip   <= 1'b0;
      o_fault_out         <= 1'b0;
      o_link_enable       <= 1'b0;
      o_minor_fault_alarm <= 1'b0;
      o_err_count         <= 4'h0;
    end else begin
      // coast latches on until reset in coast modes
      o_motor.coast     <= (state_reg == ces_pkg::CES_ST_COAST) ||
                           ((state_reg == ces_pkg::CES_ST_TRIPPED) &&
                            (cfg_reg.stop_mode != `CES_STOP_DECEL));
      o_motor.decel     <= (state_reg == ces_pkg::CES_ST_DECEL) ||
                           (state_reg == ces_pkg::CES_ST_HOLD) ||
                           ((state_reg == ces_pkg::CES_ST_TRIPPED) &&
                            (cfg_reg.stop_mode == `CES_STOP_DECEL));
      o_motor.restart   <= mode2_clear;
      o_comm_fault_trip <= (state_reg == ces_pkg::CES_ST_COAST) ||
                           (state_reg == ces_pkg::CES_ST_TRIPPED) ||
                           (state_reg == ces_pkg::CES_ST_HOLD);
      // mode 2 shows the fault but never drives the fault output
      o_fault_out       <= (state_reg == ces_pkg::CES_ST_COAST) ||
                           (state_reg == ces_pkg::CES_ST_TRIPPED);
      o_link_enable     <= ~refuse_reg;
      o_minor_fault_alarm <= minor_reg;
      o_err_count       <= err_cnt_reg;
    end
  end

  // alarm routing to the output terminals
  // terminal routing
  ces_term_map #(
    .N_TERM (N_TERM)
  ) u_term_map (
    .i_mclk  (i_mclk),
    .i_rst   (i_rst),
    .i_minor (minor_reg),
    .i_func  (i_output_terminal_function),
    .o_term  (o_term)
  );

endmodule

// [bench/ces_host_model.sv]
`timescale 1ns/1ps
// host link master: turns bench requests into one-cycle frame pulses
module ces_host_model (
  // clock
  input  wire logic i_mclk,
  // frame requests
  input  wire logic i_send,
  input  wire logic i_bad,
  // frame events
  output logic      o_frame_ok,
  output logic      o_frame_err
);
  // host sends frames
  // registered so a frame never lands in the edge that asked for it
  always_ff @(posedge i_mclk) begin
    o_frame_ok  <= i_send && !i_bad;
    o_frame_err <= i_send && i_bad;
  end
endmodule

// [bench/ces_supervisor_sva.sv]
`timescale 1ns/1ps
`include "ces_regs.svh"
module ces_supervisor_sva #(
  parameter int N_TERM      = 3,
  parameter int TICK_CYCLES = 10
) (
  // clock, reset, inputs
  input wire logic                i_mclk,
  input wire logic                i_rst,
  input wire logic                i_frame_ok,
  input wire logic                i_frame_err,
  input wire logic                i_cfg_changed,
  input wire logic                i_set_wr,
  input wire ces_pkg::ces_sel_e   i_set_sel,
  input wire logic [15:0]         i_set_data,
  input wire logic [15:0]         i_user_group_read_select,
  input wire logic                i_comm_opt_attached,
  input wire logic                i_motor_stopped,
  // outputs
  input wire logic                o_link_enable,
  input wire logic                o_set_ack,
  input wire logic                o_set_nak,
  input wire ces_pkg::ces_motor_s o_motor,
  input wire logic                o_comm_fault_trip,
  input wire logic                o_fault_out,
  input wire logic [3:0]          o_err_count
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  // a frame the link still takes, with no setting change in flight and no trip shown
  sequence live_s;
    o_link_enable && !o_set_ack && !$past(i_cfg_changed) && !o_comm_fault_trip;
  endsequence
  sequence bad_s;
    i_frame_err && !i_frame_ok && !$past(i_frame_err) && !$past(i_frame_ok)
      && o_err_count < 4'hE ##0 live_s;
  endsequence
  sequence good_s;
    i_frame_ok && !i_frame_err ##0 live_s ##1 !i_frame_err;
  endsequence
  a_err_count: assert property (bad_s |-> ##2 o_err_count == $past(o_err_count, 2) + 4'h1)
    else $error("error count did not step");
  a_good_clears: assert property (good_s |-> ##1 o_err_count == 4'h0)
    else $error("good frame left error count");
  a_set_answer: assert property (i_set_wr |=> o_set_ack != o_set_nak)
    else $error("write not answered once");
  a_set_locked: assert property (i_set_wr && i_user_group_read_select != 16'h0000
    && !i_comm_opt_attached |=> o_set_nak) else $error("locked write accepted");
  a_retry_range: assert property (i_set_wr && i_set_sel == ces_pkg::CES_SEL_RETRY
    && i_set_data > `CES_RETRY_MAX && i_set_data != `CES_DISABLE_CODE |=> o_set_nak)
    else $error("retry limit out of range accepted");
  a_link_refuse: assert property (o_set_ack |=> !o_link_enable)
    else $error("link open after setting write");
  a_cfg_refuse: assert property (i_cfg_changed |-> ##2 !o_link_enable)
    else $error("link open after setting change");
  a_link_stays: assert property ($fell(o_link_enable) |-> !o_link_enable [*4])
    else $error("link reopened without reset");
  a_coast_fault: assert property ($rose(o_motor.coast) |-> o_comm_fault_trip && o_fault_out)
    else $error("coast without fault output");
  a_decel_first: assert property ($rose(o_fault_out) && o_motor.decel
    |-> $past(i_motor_stopped, 2) || $past(i_motor_stopped, 3)) else $error("fault before stop");
endmodule
bind ces_supervisor ces_supervisor_sva #(.N_TERM(N_TERM), .TICK_CYCLES(TICK_CYCLES)) sva_inst (
  .i_mclk(i_mclk), .i_rst(i_rst), .i_frame_ok(i_frame_ok), .i_frame_err(i_frame_err),
  .i_cfg_changed(i_cfg_changed), .i_set_wr(i_set_wr), .i_set_sel(i_set_sel),
  .i_set_data(i_set_data), .i_user_group_read_select(i_user_group_read_select),
  .i_comm_opt_attached(i_comm_opt_attached), .i_motor_stopped(i_motor_stopped),
  .o_link_enable(o_link_enable), .o_set_ack(o_set_ack), .o_set_nak(o_set_nak),
  .o_motor(o_motor), .o_comm_fault_trip(o_comm_fault_trip), .o_fault_out(o_fault_out),
  .o_err_count(o_err_count));

// [bench/ces_supervisor_test.sv]
`timescale 1ns/1ps
`include "ces_regs.svh"
module ces_supervisor_test;
  logic                i_mclk, i_rst, send, bad, f_ok, f_err, cfg_chg, lmode, set_wr, opt, mstop;
  logic                link_en, ack, nak, trip, fout, minor;
  ces_pkg::ces_sel_e   sel;
  ces_pkg::ces_motor_s motor;
  logic [15:0]         sdata, rsel;
  logic [2:0][15:0]    tfunc;
  logic [3:0]          errc;
  logic [2:0]          term;
  logic [31:0]         seed;
  int                  bad_count, num_checks;
  int                  cycles = 0;
  // one-cycle tick keeps silence intervals short enough to run out in simulation
  ces_supervisor #(.N_TERM(3), .TICK_CYCLES(1)) ces_supervisor_inst (
    .i_mclk(i_mclk), .i_rst(i_rst), .i_frame_ok(f_ok), .i_frame_err(f_err),
    .i_cfg_changed(cfg_chg), .i_link_cmd_mode(lmode), .i_set_wr(set_wr), .i_set_sel(sel),
    .i_set_data(sdata), .i_user_group_read_select(rsel), .i_comm_opt_attached(opt),
    .i_output_terminal_function(tfunc), .i_motor_stopped(mstop), .o_link_enable(link_en),
    .o_set_ack(ack), .o_set_nak(nak), .o_motor(motor), .o_comm_fault_trip(trip),
    .o_fault_out(fout), .o_minor_fault_alarm(minor), .o_err_count(errc), .o_term(term));
  ces_host_model ces_host_model_inst (
    .i_mclk(i_mclk), .i_send(send), .i_bad(bad), .o_frame_ok(f_ok), .o_frame_err(f_err));
  // clock
  initial begin
    i_mclk = 1'b0;
    forever #2.5 i_mclk = ~i_mclk;
  end
  // seed stepping and expectations per stop mode
  function automatic logic lfsr_bit(input logic [31:0] s);
    return s[0];
  endfunction
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {1'b0, s[31:1]} ^ (lfsr_bit(s) ? 32'h8020_0003 : 32'h0000_0000);
  endfunction
  function automatic logic exp_coast(input logic [1:0] m);
    return m != `CES_STOP_DECEL && m != `CES_STOP_RESTART;
  endfunction
  function automatic logic exp_fault(input logic [1:0] m, input logic st);
    return m != `CES_STOP_RESTART && (st || m != `CES_STOP_DECEL);
  endfunction
  task automatic complete_run;
    if (bad_count == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: expected %h got %h", $time, exp, got);
    end
  endtask
  // wait n edges, then let that edge's updates land
  task automatic look(input int n);
    repeat (n) @(posedge i_mclk);
    #1;
  endtask
  task automatic do_reset;
    @(posedge i_mclk);
    i_rst <= 1'b1;
    lmode <= 1'b0;
    mstop <= 1'b0;
    repeat (5) @(posedge i_mclk);
    i_rst <= 1'b0;
    look(2);
  endtask
  task automatic frame(input logic b);
    @(posedge i_mclk);
    send <= 1'b1;
    bad  <= b;
    @(posedge i_mclk);
    send <= 1'b0;
  endtask
  task automatic write_set(input ces_pkg::ces_sel_e s, input logic [15:0] d, input logic ok);
    @(posedge i_mclk);
    set_wr <= 1'b1;
    sel    <= s;
    sdata  <= d;
    @(posedge i_mclk);
    set_wr <= 1'b0;
    #1;
    chk({6'h00, ack, nak}, {6'h00, ok, !ok});
  endtask
  // hang guard
  always @(posedge i_mclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      bad_count++;
      complete_run;
    end
  end
  initial begin
    {i_rst, send, bad, cfg_chg, lmode, set_wr, opt, mstop} = 8'h80;
    sel = ces_pkg::CES_SEL_NONE;
    sdata = 16'h0000;
    rsel = 16'h0000;
    tfunc = {16'h0005, `CES_LF_NEG_CODE, `CES_LF_POS_CODE};
    seed = 32'h0001_70A1;
    bad_count = 0;
    num_checks = 0;
    do_reset;
    chk(8'(link_en), 8'h01);
    chk(8'(term), 8'h02);
    // default limit of one tolerates a single error
    frame(1'b1);
    look(4);
    chk({3'h0, trip, errc}, 8'h01);
    frame(1'b0);
    look(4);
    chk(8'(errc), 8'h00);
    seed = lfsr_next(seed);
    frame(1'b1);
    repeat (seed[1:0]) @(posedge i_mclk);
    frame(1'b1);
    look(8);
    chk({5'h00, trip, fout, motor.coast}, 8'h07);
    // another link setting change closes the link until reset
    do_reset;
    @(posedge i_mclk);
    cfg_chg <= 1'b1;
    @(posedge i_mclk);
    cfg_chg <= 1'b0;
    look(3);
    chk(8'(link_en), 8'h00);
    frame(1'b1);
    look(4);
    chk(8'(errc), 8'h00);
    seed = lfsr_next(seed);
    rsel <= seed[15:0] | 16'h0001;
    write_set(ces_pkg::CES_SEL_RETRY, 16'h0005, 1'b0);
    opt <= 1'b1;
    write_set(ces_pkg::CES_SEL_RETRY, 16'h000B + {8'h00, seed[23:16]}, 1'b0);
    write_set(ces_pkg::CES_SEL_RETRY, `CES_DISABLE_CODE, 1'b1);
    write_set(ces_pkg::CES_SEL_NONE, 16'h0000, 1'b0);
    // the 9999 limit goes live at reset: errors raise the minor alarm only
    do_reset;
    frame(1'b1);
    frame(1'b1);
    look(4);
    chk({3'h0, trip, minor, term}, 8'h09);
    chk(8'(term), 8'h01);
    frame(1'b0);
    look(4);
    chk({3'h0, trip, minor, term}, 8'h02);
    // limit 0 trips on the first error once live
    write_set(ces_pkg::CES_SEL_RETRY, 16'h0000, 1'b1);
    // every stop mode, tripped by a zero timeout in link command mode
    for (int m = 0; m < 4; m++) begin
      do_reset;
      opt  <= m[0];
      rsel <= m[0] ? (seed[15:0] | 16'h0001) : 16'h0000;
      write_set(ces_pkg::CES_SEL_STOP, 16'(m), 1'b1);
      look(1);
      chk(8'(link_en), 8'h00);
      do_reset;
      @(posedge i_mclk);
      lmode <= 1'b1;
      look(8);
      chk({5'h00, trip, fout, motor.coast},
        {5'h00, exp_coast(m[1:0]), exp_fault(m[1:0], 1'b0), exp_coast(m[1:0])});
      @(posedge i_mclk);
      mstop <= 1'b1;
      look(8);
      chk({5'h00, trip, fout, motor.decel},
        {5'h00, 1'b1, exp_fault(m[1:0], 1'b1), !exp_coast(m[1:0])});
    end
    // mode 2: a receive error trips, a good frame while slowing restarts
    write_set(ces_pkg::CES_SEL_STOP, 16'h0002, 1'b1);
    do_reset;
    frame(1'b1);
    look(6);
    chk({5'h00, trip, fout, motor.decel}, 8'h01);
    frame(1'b0);
    look(1);
    chk(8'(motor.restart), 8'h01);
    look(1);
    chk({5'h00, motor.restart, motor.decel, trip}, 8'h00);
    // silence of 30 tenths: trip shows about 34 cycles after the last frame
    write_set(ces_pkg::CES_SEL_TIMEOUT, 16'h001E, 1'b1);
    write_set(ces_pkg::CES_SEL_STOP, 16'h0000, 1'b1);
    do_reset;
    lmode <= 1'b1;
    repeat (5) begin
      look(18);
      frame(1'b0);
    end
    look(25);
    chk(8'(trip), 8'h00);
    look(20);
    chk({6'h00, trip, fout}, 8'h03);
    // 9999 turns the check off; a live check would trip near 10,000 cycles
    write_set(ces_pkg::CES_SEL_TIMEOUT, `CES_DISABLE_CODE, 1'b1);
    do_reset;
    lmode <= 1'b1;
    frame(1'b0);
    look(10100);
    chk(8'(trip), 8'h00);
    complete_run;
  end
endmodule
